/* rtl/erp_port.sv */
// parallel port read cycle engine with apb register file
`timescale 1ns/1ps
`include "erp_map.svh"

// overview of the block:
// the apb side is the host; an epp data or address read stalls pready
// the parallel side strobes the peripheral and waits for its hold line
// a watchdog ends a cycle that the peripheral never releases
// one data register is shared by standard writes and read results
// every cable input passes a two flop synchroniser before use
// the clock enable freezes every flop, the synchroniser included
// epp writes are not built; the data port only drives the standard byte

module erp_port
   import erp_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = `ERP_TIMEOUT_CYC
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic clockEnable,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic [7:0] pdataIn,
   output logic [7:0] pdataOut,
   output logic pdataOeN,
   output logic xferWriteN,
   output logic busDirectionOut,
   output logic dataStrobeN,
   output logic addrStrobeN,
   output logic periphResetN,
   input wire logic periphHoldN,
   input wire logic periphInterrupt,
   input wire logic paperOutStatus,
   input wire logic printerOnline,
   input wire logic periphErrorN
);

   // thirteen cable inputs: data byte, hold, interrupt and three status pins
   // the counter is eleven bits wide, enough for the default limit
   // a limit above 2048 cycles would need a wider counter
   localparam int SYNC_W = 13;
   localparam logic [10:0] TIMEOUT_LAST = 11'(TIMEOUT_CYCLES - 1);

   // synchronised pin inputs
   logic [SYNC_W-1:0] pinsSync;
   logic [7:0] pdataSync;
   logic holdSync;
   logic intrSync;
   logic paperSync;
   logic onlineSync;
   logic errorSync;

   // register state
   // shared data byte: standard writes and read results
   logic [7:0] data_q;
   logic [7:0] data_d;
   // control byte: strobe, autofd, init, selectin, ackIntEn, direction
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   // sticky watchdog flag shown in status bit zero
   logic timeout_q;
   logic timeout_d;
   // sticky interrupt causes and their enables
   logic [`ERP_IRQ_WIDTH-1:0] irqStat_q;
   logic [`ERP_IRQ_WIDTH-1:0] irqStat_d;
   logic [`ERP_IRQ_WIDTH-1:0] irqMask_q;
   logic [`ERP_IRQ_WIDTH-1:0] irqMask_d;
   // last synchronised interrupt level for edge detection
   logic intrPrev_q;
   logic intrPrev_d;

   // cycle state
   // phase of the current read cycle
   erp_state_t state_q;
   erp_state_t state_d;
   // strobe cycles spent so far, compared with the watchdog limit
   logic [10:0] count_q;
   logic [10:0] count_d;
   // high when the running cycle is an address read
   logic cycleAddr_q;
   logic cycleAddr_d;
   // registered strobes so the cable sees clean edges
   logic dataStrobeN_q;
   logic dataStrobeN_d;
   logic addrStrobeN_q;
   logic addrStrobeN_d;

   // bus decode
   logic access;
   logic wrAccess;
   logic eppSel;
   logic mapped;
   logic timeoutHit;
   logic intrRise;
   logic [7:0] statusByte;

   // pin synchroniser for every input from the cable
   // data and hold share the same delay, so data that stands
   // before hold rises is still valid when the synced hold is seen
   erp_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clock(clock),
      .reset(reset),
      .clockEnable(clockEnable),
      .asyncIn({pdataIn, periphHoldN, periphInterrupt, paperOutStatus, printerOnline, periphErrorN}),
      .syncOut(pinsSync)
   );

   // split the synchronised group
   assign pdataSync = pinsSync[12:5];
   assign holdSync = pinsSync[4];
   assign intrSync = pinsSync[3];
   assign paperSync = pinsSync[2];
   assign onlineSync = pinsSync[1];
   assign errorSync = pinsSync[0];

   // apb decode; accesses only count while the clock enable is high
   // a write lands only at the edge where pready is high
   // a read of either epp port starts a read cycle, any other access answers at once
   // the watchdog hit is one cycle before the limit so the answer stays in bound
   assign access = psel & penable & clockEnable;
   assign wrAccess = access & pwrite & pready;
   assign eppSel = (paddr == `ERP_OFS_EPP_ADDR) || (paddr == `ERP_OFS_EPP_DATA);
   assign mapped = (paddr == `ERP_OFS_DATA) || (paddr == `ERP_OFS_STATUS) || (paddr == `ERP_OFS_CTRL) ||
                   eppSel || (paddr == `ERP_OFS_IRQ_STAT) || (paddr == `ERP_OFS_IRQ_MASK);
   assign timeoutHit = (count_q == TIMEOUT_LAST);
   assign intrRise = intrSync & ~intrPrev_q;

   // read cycle state machine: strobe, wait for release, answer
   // idle: a read access phase to an epp port starts a cycle one edge later
   // strobe: the chosen strobe stays low while the hold line is low
   // done: pready is high for one cycle and the access ends on that edge
   // the strobe rises on that same edge, so it follows the host read
   // a watchdog hit also goes to done and leaves the data register alone
   always_comb begin
      state_d = state_q;
      count_d = count_q;
      cycleAddr_d = cycleAddr_q;
      dataStrobeN_d = 1'b1;
      addrStrobeN_d = 1'b1;
      unique case (state_q)
         ERP_IDLE: begin
            // counter parked at zero between cycles
            count_d = '0;
            if (access && !pwrite && eppSel) begin
               state_d = ERP_STROBE;
               cycleAddr_d = (paddr == `ERP_OFS_EPP_ADDR);
               dataStrobeN_d = (paddr == `ERP_OFS_EPP_ADDR);
               addrStrobeN_d = (paddr != `ERP_OFS_EPP_ADDR);
            end
         end
         ERP_STROBE: begin
            // keep the strobe chosen at the start of the cycle
            dataStrobeN_d = cycleAddr_q;
            addrStrobeN_d = ~cycleAddr_q;
            count_d = count_q + 11'h001;
            if (timeoutHit) begin
               state_d = ERP_DONE;
            end else if (holdSync) begin
               state_d = ERP_DONE;
            end
         end
         ERP_DONE: begin
            // strobe rises with the end of the host access
            state_d = ERP_IDLE;
         end
         default: begin
            // the unused code falls back to idle
            state_d = ERP_IDLE;
         end
      endcase
   end

   // cycle registers; reset leaves both strobes high
   // a low clock enable freezes the cycle and its counter
   always_ff @(posedge clock) begin
      if (reset) begin
         state_q <= ERP_IDLE;
         count_q <= '0;
         cycleAddr_q <= 1'b0;
         dataStrobeN_q <= 1'b1;
         addrStrobeN_q <= 1'b1;
      end else if (clockEnable) begin
         state_q <= state_d;
         count_q <= count_d;
         cycleAddr_q <= cycleAddr_d;
         dataStrobeN_q <= dataStrobeN_d;
         addrStrobeN_q <= addrStrobeN_d;
      end
   end

   // register file next values, events win over software clears
   // writes only count at the accepting edge of the access
   // the status flag clears by writing one to bit zero
   // interrupt causes clear by writing ones, the mask is plain read-write
   always_comb begin
      data_d = data_q;
      ctrl_d = ctrl_q;
      timeout_d = timeout_q;
      irqStat_d = irqStat_q;
      irqMask_d = irqMask_q;
      intrPrev_d = intrSync;
      // one data register serves standard writes and read cycle results
      // standard data write
      if (wrAccess && paddr == `ERP_OFS_DATA) begin
         data_d = pwdata[7:0];
      end
      // read result taken when the peripheral releases hold
      if (state_q == ERP_STROBE && holdSync && !timeoutHit) begin
         data_d = pdataSync;
      end
      // control write, upper two bits kept at zero
      if (wrAccess && paddr == `ERP_OFS_CTRL) begin
         ctrl_d = pwdata[7:0] & `ERP_CTRL_MASK;
      end
      // software clears of the sticky flags and the mask write
      if (wrAccess && paddr == `ERP_OFS_STATUS && pwdata[`ERP_STAT_TIMEOUT]) begin
         timeout_d = 1'b0;
      end
      if (wrAccess && paddr == `ERP_OFS_IRQ_STAT) begin
         irqStat_d = irqStat_q & ~pwdata[`ERP_IRQ_WIDTH-1:0];
      end
      if (wrAccess && paddr == `ERP_OFS_IRQ_MASK) begin
         irqMask_d = pwdata[`ERP_IRQ_WIDTH-1:0];
      end
      // hardware events set last so a same-cycle clear loses
      if (state_q == ERP_STROBE && timeoutHit) begin
         timeout_d = 1'b1;
         irqStat_d[`ERP_IRQ_TIMEOUT] = 1'b1;
      end
      // rising edge of the synced interrupt pin
      if (intrRise) begin
         irqStat_d[`ERP_IRQ_PERIPH] = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         // init bit set so the peripheral reset output is high
         data_q <= 8'h00;
         ctrl_q <= `ERP_CTRL_RESET;
         timeout_q <= 1'b0;
         irqStat_q <= '0;
         irqMask_q <= '0;
         intrPrev_q <= 1'b0;
      end else if (clockEnable) begin
         data_q <= data_d;
         ctrl_q <= ctrl_d;
         timeout_q <= timeout_d;
         irqStat_q <= irqStat_d;
         irqMask_q <= irqMask_d;
         intrPrev_q <= intrPrev_d;
      end
   end

   // status byte: pin levels above, watchdog flag in bit zero
   // pin bits are the synchronised levels, two cycles behind the cable
   // bits two and one always read zero
   always_comb begin
      statusByte = 8'h00;
      statusByte[`ERP_STAT_HOLD] = holdSync;
      statusByte[`ERP_STAT_PERIPH_INTERRUPT] = intrSync;
      statusByte[`ERP_STAT_PAPER] = paperSync;
      statusByte[`ERP_STAT_ONLINE] = onlineSync;
      statusByte[`ERP_STAT_ERROR] = errorSync;
      statusByte[`ERP_STAT_TIMEOUT] = timeout_q;
   end

   // apb answer: read cycles stall until done, everything else answers at once
   // writes to the epp ports are ignored and answer at once
   // unmapped addresses answer at once with an error and zero data
   // read data is a mux of flops, valid in the cycle where pready is high
   // a low clock enable keeps an epp read stalled
   // outside an access phase prdata reads zero
   always_comb begin
      pready = 1'b1;
      pslverr = 1'b0;
      prdata = 32'h00000000;
      if (psel && penable) begin
         if (eppSel && !pwrite) begin
            pready = clockEnable && (state_q == ERP_DONE);
         end
         pslverr = ~mapped;
         unique case (paddr)
            `ERP_OFS_DATA: prdata = {24'h000000, data_q};
            `ERP_OFS_STATUS: prdata = {24'h000000, statusByte};
            `ERP_OFS_CTRL: prdata = {24'h000000, ctrl_q};
            `ERP_OFS_EPP_ADDR: prdata = {24'h000000, data_q};
            `ERP_OFS_EPP_DATA: prdata = {24'h000000, data_q};
            `ERP_OFS_IRQ_STAT: prdata = {30'h00000000, irqStat_q};
            `ERP_OFS_IRQ_MASK: prdata = {30'h00000000, irqMask_q};
            default: prdata = 32'h00000000;
         endcase
      end
   end

   // parallel-side outputs
   // direction turns to input for the whole read cycle
   // the data driver is off whenever direction is input
   // the peripheral reset follows the init bit of control
   // the interrupt is high while an enabled cause is set
   assign busDirectionOut = ctrl_q[`ERP_CTRL_DIR] | (state_q != ERP_IDLE);
   assign pdataOut = data_q;
   assign pdataOeN = busDirectionOut;
   // write is low only for an output direction, or when the control strobe bit forces it
   assign xferWriteN = ~((~busDirectionOut) | ctrl_q[`ERP_CTRL_STROBE]);
   assign dataStrobeN = dataStrobeN_q;
   assign addrStrobeN = addrStrobeN_q;
   assign periphResetN = ctrl_q[`ERP_CTRL_INIT];
   assign irq = |(irqStat_q & irqMask_q);

   // limitations: software must set the direction bit before a read
   // and clear strobe, autofd and selectin; a strobe bit left set
   // forces the write output low and the cycle is not refused
   // only one read cycle runs at a time, the next starts after idle

endmodule // erp_port

/* rtl/erp_map.svh */
// register offsets, field positions, reset values and timing counts of the parallel read port
`ifndef ERP_MAP_SVH
`define ERP_MAP_SVH

// register byte offsets on the apb bus
`define ERP_OFS_DATA 8'h00
`define ERP_OFS_STATUS 8'h04
`define ERP_OFS_CTRL 8'h08
`define ERP_OFS_EPP_ADDR 8'h0C
`define ERP_OFS_EPP_DATA 8'h10
`define ERP_OFS_IRQ_STAT 8'h14
`define ERP_OFS_IRQ_MASK 8'h18

// control register fields
`define ERP_CTRL_STROBE 0
`define ERP_CTRL_AUTOFD 1
`define ERP_CTRL_INIT 2
`define ERP_CTRL_SELIN 3
`define ERP_CTRL_ACKINTEN 4
`define ERP_CTRL_DIR 5
`define ERP_CTRL_RESET 8'h04
`define ERP_CTRL_MASK 8'h3F

// status register fields
`define ERP_STAT_TIMEOUT 0
`define ERP_STAT_ERROR 3
`define ERP_STAT_ONLINE 4
`define ERP_STAT_PAPER 5
`define ERP_STAT_PERIPH_INTERRUPT 6
`define ERP_STAT_HOLD 7

// interrupt status and mask fields
`define ERP_IRQ_PERIPH 0
`define ERP_IRQ_TIMEOUT 1
`define ERP_IRQ_WIDTH 2

// cycle watchdog: time in microseconds, clock in MHz, derived cycle count
`define ERP_TIMEOUT_US 10
`define ERP_CLOCK_MHZ 200
`define ERP_TIMEOUT_CYC (`ERP_TIMEOUT_US * `ERP_CLOCK_MHZ)

`endif

/* rtl/erp_pkg.sv */
// types shared by the parallel read port
package erp_pkg;

   // read cycle states
   typedef enum logic [1:0] {
      ERP_IDLE = 2'b00,
      ERP_STROBE = 2'b01,
      ERP_DONE = 2'b10
   } erp_state_t;

endpackage

/* rtl/erp_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module erp_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic clockEnable,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;

   // one generated pair of flops per bit; the first stage feeds only the second
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock) begin
         if (reset) begin
            stage1_q[i] <= 1'b0;
            stage2_q[i] <= 1'b0;
         end else if (clockEnable) begin
            stage1_q[i] <= asyncIn[i];
            stage2_q[i] <= stage1_q[i];
         end
      end
   end

   assign syncOut = stage2_q;

endmodule // erp_sync

/* test/erp_port_asserts.sv */
// assertion checker for the parallel read port
`timescale 1ns/1ps
module erp_port_asserts #(
   parameter int TIMEOUT_CYCLES = 20
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic [7:0] paddr,
   input wire logic dataStrobeN,
   input wire logic addrStrobeN,
   input wire logic busDirectionOut,
   input wire logic pdataOeN,
   input wire logic periphResetN,
   input wire logic periphHoldN
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic stb;
   logic [15:0] cnt_d, cnt_q;
   // cycles the strobe has been held low
   assign stb = !(dataStrobeN && addrStrobeN);
   always_comb cnt_d = stb ? cnt_q + 16'h0001 : 16'h0000;
   always_ff @(posedge clock) cnt_q <= reset ? 16'h0000 : cnt_d;
   sequence accessTo(a);
      psel && penable && paddr == a;
   endsequence
   sequence holdLow;
      !periphHoldN [*4];
   endsequence
   AST_DATA_STB: assert property ($fell(dataStrobeN) |-> $past(psel && penable && paddr == 8'h10))
      else $error("data strobe without data read");
   AST_ADDR_STB: assert property ($fell(addrStrobeN) |-> $past(psel && penable && paddr == 8'h0C))
      else $error("address strobe without address read");
   AST_STB_END: assert property (stb && psel && penable && pready |=> !stb)
      else $error("strobe kept after read end");
   AST_STB_KEEP: assert property (stb && !(psel && penable && pready) |=> stb)
      else $error("strobe dropped early");
   AST_READ_PINS: assert property (stb |-> busDirectionOut && pdataOeN)
      else $error("bus not turned for read");
   AST_HOLD_WAIT: assert property (holdLow ##0 (stb && cnt_q < TIMEOUT_CYCLES - 4) |-> !pready)
      else $error("ready while wait low");
   AST_WATCHDOG: assert property (cnt_q <= TIMEOUT_CYCLES + 2)
      else $error("cycle not aborted");
   AST_PLAIN_RDY: assert property (accessTo(8'h00) or accessTo(8'h08) |-> pready)
      else $error("plain access stalled");
   AST_RESET_PINS: assert property ($fell(reset) |-> !stb && periphResetN && !busDirectionOut)
      else $error("pins wrong after reset");
endmodule // erp_port_asserts
bind erp_port erp_port_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) erp_port_asserts_i (.*);

/* test/erp_periph_model.sv */
// behavioural peripheral on the parallel cable
`timescale 1ns/1ps
module erp_periph_model (
   input wire logic clock,
   input wire logic dataStrobeN,
   input wire logic addrStrobeN,
   input wire logic pdataOeN,
   input wire logic [7:0] pdataOut,
   input wire logic [7:0] rdByte,
   input wire logic [7:0] lag,
   output logic periphHoldN,
   output logic [7:0] pdataIn
);
   logic [7:0] cnt;
   logic drv;
   // answer a strobe after lag cycles: data first, wait release three cycles on
   always @(posedge clock) begin
      if (dataStrobeN && addrStrobeN) begin
         cnt <= 8'h00;
         drv <= 1'b0;
         periphHoldN <= 1'b0;
      end else begin
         cnt <= cnt + 8'h01;
         if (cnt == lag) drv <= 1'b1;
         if (cnt == lag + 8'h03) periphHoldN <= 1'b1;
      end
   end
   // wire level: our byte, the device byte, or the inverse when floated
   assign pdataIn = drv ? rdByte : (pdataOeN ? ~rdByte : pdataOut);
endmodule // erp_periph_model

/* test/epp17_read_cycle_port_test.sv */
// self-checking bench for the parallel read port
`timescale 1ns/1ps
module epp17_read_cycle_port_test;
   logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, periph_interrupt = 0, paper = 0, online = 0, errN = 1;
   logic [7:0] paddr = 0, pdataIn, pdataOut, rdByte = 0, lag = 0, old;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, irq, pdataOeN, xferWriteN, busDirectionOut, dataStrobeN, addrStrobeN;
   logic periphResetN, periphHoldN, err;
   int n_mismatch = 0, cmp_count = 0;
   logic [7:0] tbl [4] = '{8'h00, 8'h01, 8'h20, 8'h04};
   always #2.5 clock = ~clock;
   erp_port #(.TIMEOUT_CYCLES(20)) erp_port_i (.clock, .reset, .clockEnable(1'b1), .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .pdataIn, .pdataOut, .pdataOeN, .xferWriteN,
      .busDirectionOut, .dataStrobeN, .addrStrobeN, .periphResetN, .periphHoldN, .periphInterrupt(periph_interrupt),
      .paperOutStatus(paper), .printerOnline(online), .periphErrorN(errN));
   erp_periph_model erp_periph_model_i (.clock, .dataStrobeN, .addrStrobeN, .pdataOeN, .pdataOut, .rdByte,
      .lag, .periphHoldN, .pdataIn);
   function automatic logic exp_wn(logic [7:0] c);
      return c[5] & ~c[0];
   endfunction
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one apb transfer: request held until pready is seen high at a rising edge, answer taken there
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 200);
      if (pready !== 1'b1) begin
         n_mismatch++;
         end_sim;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so registered outputs have settled before any check
      @(posedge clock);
   endtask
   // main sequence
   initial begin
      void'($urandom(15545));
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      apb(0, 8'h08, 0);
      chk("ctrl", rd, 32'h04);
      apb(0, 8'h1C, 0);
      chk("unmapped", err, 1);
      $display("registers done");
      for (int i = 0; i < 8; i++) begin
         lag <= 8'($urandom_range(0, 12));
         rdByte <= 8'($urandom);
         {paper, online, errN} <= 3'($urandom);
         apb(1, 8'h08, 32'h20);
         apb(0, i[0] ? 8'h0C : 8'h10, 0);
         chk("read", rd, {24'h0, rdByte});
         apb(0, 8'h00, 0);
         chk("shared", rd, {24'h0, rdByte});
         apb(0, 8'h04, 0);
         chk("status pins", rd[5:3], {paper, online, errN});
      end
      $display("reads done");
      old = rdByte;
      lag <= 8'hC8;
      rdByte <= ~old;
      apb(0, 8'h10, 0);
      chk("aborted", rd, {24'h0, old});
      apb(0, 8'h04, 0);
      chk("flag", rd[0], 1);
      apb(1, 8'h18, 32'h02);
      chk("irq on", irq, 1);
      apb(1, 8'h14, 32'h02);
      chk("irq off", irq, 0);
      $display("timeout done");
      periph_interrupt <= 1'b1;
      apb(1, 8'h18, 32'h01);
      chk("periph_interrupt", irq, 1);
      apb(1, 8'h14, 32'h01);
      chk("periph_interrupt clr", irq, 0);
      $display("interrupt done");
      foreach (tbl[k]) begin
         apb(1, 8'h08, {24'h0, tbl[k]});
         chk("reset out", periphResetN, tbl[k][2]);
         chk("write out", xferWriteN, exp_wn(tbl[k]));
         chk("direction", busDirectionOut, tbl[k][5]);
      end
      $display("pins done");
      end_sim;
   end
endmodule // epp17_read_cycle_port_test
